// file: rtl/dmrb_defines.vh
`ifndef DMRB_DEFINES_VH
`define DMRB_DEFINES_VH

// command strobes {cs_n, ras_n, cas_n, we_n}
`define DMRB_CMD_MRS 4'h0
`define DMRB_CMD_RD 4'h5
`define DMRB_CMD_WR 4'h4

// bank address that selects the target mode register
`define DMRB_BA_OPMODE 3'h0
`define DMRB_BA_EXT1 3'h1

// operating-mode register fields
`define DMRB_OM_BL_LO 0
`define DMRB_OM_BL_HI 1
`define DMRB_OM_CL_HALF 2
`define DMRB_OM_BT 3
`define DMRB_OM_CL_LO 4
`define DMRB_OM_CL_HI 6
`define DMRB_OM_TEST 7
`define DMRB_OM_DLLRST 8
`define DMRB_OM_WR_LO 9
`define DMRB_OM_WR_HI 11
`define DMRB_OM_PDFAST 12

// burst-length field codes
`define DMRB_BL_FIX8 2'h0
`define DMRB_BL_OTF 2'h1
`define DMRB_BL_FIX4 2'h2

// extended mode register one fields
`define DMRB_E1_AL_LO 3
`define DMRB_E1_AL_HI 4
`define DMRB_E1_WLVL 7
`define DMRB_E1_QOFF 12

// additive latency codes
`define DMRB_AL_ZERO 2'h0
`define DMRB_AL_CLM1 2'h1
`define DMRB_AL_CLM2 2'h2

// address bit that picks chop per command, and the write half bit
`define DMRB_ADDR_CHOP 12
`define DMRB_ADDR_HALF 2

// reset values of both mode registers
`define DMRB_OPMODE_RST 13'h0000
`define DMRB_EXT1_RST 13'h0000

// column latency = field + base, in clocks
`define DMRB_CL_BASE 5'h04

// fixed chop pulls the internal write in by this many clocks
`define DMRB_CHOP_PULLIN 4'h2

// precharge time in ns and its cycle count at 4 ns, rounded up
`define DMRB_TRP_NS 14
`define DMRB_CLK_NS 4
`define DMRB_TRP_CYC ((`DMRB_TRP_NS + `DMRB_CLK_NS - 1) / `DMRB_CLK_NS)

`endif

// file: rtl/dmrb_core.v
// Notes on behaviour
// - All strobes and bank bits low: load operating-mode register from address pins.
// - Strobes low, bank bit 0 high, others low: load extended register one.
// - Write recovery at A9-A11 plus precharge time gives auto-precharge delay.
// - Column latency field at A4-A6 sets read-to-first-data clocks; A2 is ignored.
// - Only whole-clock column latencies; half-clock latency never used.
// - Read data starts after additive latency plus column latency clocks.
// - A3 selects burst order: zero sequential, one interleaved.
// - A0-A1 pick fixed chop, fixed eight or per-command chop via A12.
// - Sequential eight: start half wrapped from start column, then other half.
// - Interleaved eight: column is start column XOR beat index.
// - Chopped read: four beats from start half, drivers off for four slots.
// - Writes ignore low column bits; chop starts at 0 or 4 by A2.
// - Fixed chop write starts internally two clocks earlier; per-command keeps eight timing.
// - Loop reset bit clears itself once the reset is carried out.
// - A12 picks frozen loop slow exit or active loop short exit.
// - Output disable set: data and both strobe drivers disconnected.
`timescale 1ns/1ps
`include "dmrb_defines.vh"
`default_nettype none

module dmrb_core (
    input wire clk,
    input wire reset,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [2:0] ba,
    input wire [12:0] addr,
    input wire cke,
    input wire [63:0] core_rd_words,
    input wire rd_ready,
    output reg [7:0] rd_data_q,
    output reg [2:0] rd_col_q,
    output reg rd_valid_q,
    output reg dq_oe_q,
    output reg dqs_oe_q,
    output reg [12:0] opmode_q,
    output reg [12:0] ext1_q,
    output reg dll_reset_pulse_q,
    output reg pd_fast_exit_q,
    output reg test_mode_q,
    output reg [4:0] auto_pre_delay_q,
    output reg wr_cmd_q,
    output reg [2:0] wr_start_col_q,
    output reg wr_chop_q,
    output reg [3:0] wr_pullin_q,
    output reg rd_busy_q
);

    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_BEAT = 2'h2;

    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire is_mrs = cke && (cmd == `DMRB_CMD_MRS);
    wire is_rd = cke && (cmd == `DMRB_CMD_RD);
    wire is_wr = cke && (cmd == `DMRB_CMD_WR);

    // burst length decision shared by reads and writes
    wire [1:0] bl_mode = opmode_q[`DMRB_OM_BL_HI:`DMRB_OM_BL_LO];
    wire chop_now = (bl_mode == `DMRB_BL_FIX4) ||
        ((bl_mode == `DMRB_BL_OTF) && !addr[`DMRB_ADDR_CHOP]);

    // column latency: the half-clock bit is never honoured
    wire [4:0] cl_cyc = {2'h0, opmode_q[`DMRB_OM_CL_HI:`DMRB_OM_CL_LO]} +
        `DMRB_CL_BASE;
    wire [1:0] al_code = ext1_q[`DMRB_E1_AL_HI:`DMRB_E1_AL_LO];
    reg [4:0] al_cyc;
    // additive latency in clocks from its code
    always @* begin
        case (al_code)
            `DMRB_AL_CLM1: al_cyc = cl_cyc - 5'h01;
            `DMRB_AL_CLM2: al_cyc = cl_cyc - 5'h02;
            default: al_cyc = 5'h00;
        endcase
    end
    wire [5:0] rl_cyc = {1'b0, al_cyc} + {1'b0, cl_cyc};

    // write recovery code to clocks
    reg [4:0] wr_cyc;
    always @* begin
        case (opmode_q[`DMRB_OM_WR_HI:`DMRB_OM_WR_LO])
            3'h1: wr_cyc = 5'h05;
            3'h2: wr_cyc = 5'h06;
            3'h3: wr_cyc = 5'h07;
            3'h4: wr_cyc = 5'h08;
            3'h5: wr_cyc = 5'h0a;
            3'h6: wr_cyc = 5'h0c;
            3'h7: wr_cyc = 5'h0e;
            default: wr_cyc = 5'h10;
        endcase
    end

    // mode register loads; loop reset bit clears itself after one clock
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            opmode_q <= `DMRB_OPMODE_RST;
            ext1_q <= `DMRB_EXT1_RST;
            dll_reset_pulse_q <= 1'b0;
        end else begin
            dll_reset_pulse_q <= opmode_q[`DMRB_OM_DLLRST];
            if (is_mrs && ba == `DMRB_BA_OPMODE) begin
                opmode_q <= addr;
            end else if (opmode_q[`DMRB_OM_DLLRST]) begin
                opmode_q[`DMRB_OM_DLLRST] <= 1'b0;
            end
            if (is_mrs && ba == `DMRB_BA_EXT1) begin
                ext1_q <= addr;
            end
        end
    end

    // precharge clocks held at full width, then cut on purpose to 5 bits
    wire [31:0] trp_full = `DMRB_TRP_CYC;
    wire [4:0] trp_cyc = trp_full[4:0];

    // derived mode outputs, registered so each port leaves a flop
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pd_fast_exit_q <= 1'b0;
            test_mode_q <= 1'b0;
            auto_pre_delay_q <= 5'h00;
        end else begin
            pd_fast_exit_q <= opmode_q[`DMRB_OM_PDFAST];
            test_mode_q <= opmode_q[`DMRB_OM_TEST];
            auto_pre_delay_q <= wr_cyc + trp_cyc;
        end
    end

    // write start column and internal timing pull-in
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_cmd_q <= 1'b0;
            wr_start_col_q <= 3'h0;
            wr_chop_q <= 1'b0;
            wr_pullin_q <= 4'h0;
        end else begin
            wr_cmd_q <= is_wr;
            if (is_wr) begin
                wr_chop_q <= chop_now;
                // low column bits are ignored; chop picks the half
                wr_start_col_q <= (chop_now && addr[`DMRB_ADDR_HALF]) ?
                    3'h4 : 3'h0;
                // only a chop fixed by the mode register pulls in
                wr_pullin_q <= (bl_mode == `DMRB_BL_FIX4) ?
                    `DMRB_CHOP_PULLIN : 4'h0;
            end
        end
    end

    // read burst sequencer feeding the two-entry buffer
    reg [1:0] state_q;
    reg [5:0] lat_q;
    reg [2:0] beat_q;
    reg [2:0] start_q;
    reg chop_q;
    reg ilv_q;
    reg [63:0] words_q;
    reg in_ready_q;

    wire push = (state_q == ST_BEAT) && in_ready_q;
    wire [2:0] seq_col = {start_q[2] ^ beat_q[2], start_q[1:0] + beat_q[1:0]};
    wire [2:0] ilv_col = start_q ^ beat_q;
    wire [2:0] beat_col = ilv_q ? ilv_col : seq_col;
    // chop leaves the back four slots undriven; output disable always
    wire beat_drv = !(chop_q && beat_q[2]) &&
        !ext1_q[`DMRB_E1_QOFF];
    wire [7:0] beat_data = words_q[{beat_col, 3'h0} +: 8];

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            lat_q <= 6'h00;
            beat_q <= 3'h0;
            start_q <= 3'h0;
            chop_q <= 1'b0;
            ilv_q <= 1'b0;
            words_q <= 64'h0;
            rd_busy_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // a read during a burst is dropped; controller spaces them
                    if (is_rd) begin
                        start_q <= addr[2:0];
                        chop_q <= chop_now;
                        ilv_q <= opmode_q[`DMRB_OM_BT];
                        words_q <= core_rd_words;
                        lat_q <= rl_cyc - 6'h01;
                        beat_q <= 3'h0;
                        rd_busy_q <= 1'b1;
                        state_q <= (rl_cyc <= 6'h01) ? ST_BEAT : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    lat_q <= lat_q - 6'h01;
                    if (lat_q == 6'h01) begin
                        state_q <= ST_BEAT;
                    end
                end
                ST_BEAT: begin
                    // a full buffer stalls the beat, no word is lost
                    if (push) begin
                        beat_q <= beat_q + 3'h1;
                        if (beat_q == 3'h7) begin
                            state_q <= ST_IDLE;
                            rd_busy_q <= 1'b0;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // two-entry buffer: output stage plus skid entry
    reg [7:0] skid_data_q;
    reg [2:0] skid_col_q;
    reg skid_drv_q;
    reg skid_valid_q;
    wire out_free = !rd_valid_q || rd_ready;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 8'h00;
            rd_col_q <= 3'h0;
            rd_valid_q <= 1'b0;
            dq_oe_q <= 1'b0;
            dqs_oe_q <= 1'b0;
            skid_data_q <= 8'h00;
            skid_col_q <= 3'h0;
            skid_drv_q <= 1'b0;
            skid_valid_q <= 1'b0;
            in_ready_q <= 1'b1;
        end else begin
            if (out_free) begin
                if (skid_valid_q) begin
                    rd_data_q <= skid_data_q;
                    rd_col_q <= skid_col_q;
                    dq_oe_q <= skid_drv_q;
                    dqs_oe_q <= skid_drv_q;
                    rd_valid_q <= 1'b1;
                    skid_valid_q <= 1'b0;
                    in_ready_q <= 1'b1;
                end else if (push) begin
                    rd_data_q <= beat_data;
                    rd_col_q <= beat_col;
                    dq_oe_q <= beat_drv;
                    dqs_oe_q <= beat_drv;
                    rd_valid_q <= 1'b1;
                end else begin
                    rd_valid_q <= 1'b0;
                    dq_oe_q <= 1'b0;
                    dqs_oe_q <= 1'b0;
                end
            end else if (push) begin
                // receiver stalled: park the beat and close the input
                skid_data_q <= beat_data;
                skid_col_q <= beat_col;
                skid_drv_q <= beat_drv;
                skid_valid_q <= 1'b1;
                in_ready_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// file: verification/dmrb_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dmrb_chk (
    input wire clk,
    input wire reset,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [2:0] ba,
    input wire [12:0] addr,
    input wire cke,
    input wire rd_ready,
    input wire [7:0] rd_data_q,
    input wire [2:0] rd_col_q,
    input wire rd_valid_q,
    input wire dq_oe_q,
    input wire dqs_oe_q,
    input wire [12:0] opmode_q,
    input wire [12:0] ext1_q,
    input wire dll_reset_pulse_q,
    input wire pd_fast_exit_q,
    input wire test_mode_q,
    input wire wr_cmd_q,
    input wire wr_chop_q,
    input wire [2:0] wr_start_col_q,
    input wire [3:0] wr_pullin_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // mode set decode; a reload of the same register masks the clear
    wire mrs = cke && {cs_n, ras_n, cas_n, we_n} == 4'h0;
    wire set_om = mrs && ba == 3'h0;
    AST_OM_LOAD: assert property (set_om |=> opmode_q == $past(addr))
        else $error("operating mode register not loaded");
    AST_E1_LOAD: assert property (mrs && ba == 3'h1 |=> ext1_q == $past(addr))
        else $error("extended register not loaded");
    AST_LOOP_CLR: assert property (opmode_q[8] && !set_om |=>
        !opmode_q[8] && dll_reset_pulse_q) else $error("loop reset stuck");
    AST_PD_TEST: assert property (set_om |-> ##2
        {pd_fast_exit_q, test_mode_q} == $past({addr[12], addr[7]}, 2))
        else $error("exit or test copy wrong");
    AST_QOFF: assert property (ext1_q[12] && $past(ext1_q[12]) |->
        !dq_oe_q && !dqs_oe_q) else $error("drivers on while disabled");
    AST_PULLIN: assert property (wr_cmd_q |->
        wr_pullin_q == (opmode_q[1:0] == 2'h2 ? 4'h2 : 4'h0))
        else $error("write pull-in wrong");
    AST_WR_COL: assert property (wr_cmd_q |-> wr_start_col_q[1:0] == 2'h0)
        else $error("write start column low bits set");
    AST_RD_HOLD: assert property (rd_valid_q && !rd_ready |=> rd_valid_q &&
        $stable({rd_data_q, rd_col_q})) else $error("beat lost on stall");
    cover property (dll_reset_pulse_q);
    cover property (rd_valid_q && !rd_ready);
    cover property (wr_cmd_q && wr_chop_q);
endmodule
bind dmrb_core dmrb_chk u_chk (.*);
`default_nettype wire

// file: verification/dmrb_recv_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmrb_recv_model (
    input wire logic clk,
    input wire logic slow,
    output logic rd_ready
);
    logic [1:0] cnt_q = 2'h0;
    initial rd_ready = 1'b1;
    // slow mode stalls three cycles in four so the buffer fills up
    always @(posedge clk) begin
        cnt_q <= cnt_q + 2'h1;
        rd_ready <= #1 !slow || cnt_q == 2'h3;
    end
endmodule
`default_nettype wire

// file: verification/dmrb_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module dmrb_core_test;
    logic clk = 1'b0, reset = 1'b1, cke = 1'b1, slow = 1'b0;
    logic cs_n = 1'b1, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1;
    logic [2:0] ba = 3'h0;
    logic [12:0] addr = 13'h0000;
    logic [63:0] core_rd_words = 64'hf7e6d5c4b3a29180;
    logic rd_ready, rd_valid_q, dq_oe_q, dqs_oe_q, dll_reset_pulse_q;
    logic pd_fast_exit_q, test_mode_q, wr_cmd_q, wr_chop_q, rd_busy_q;
    logic [7:0] rd_data_q;
    logic [2:0] rd_col_q, wr_start_col_q;
    logic [12:0] opmode_q, ext1_q;
    logic [4:0] auto_pre_delay_q;
    logic [3:0] wr_pullin_q;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    dmrb_core dut (.*);
    dmrb_recv_model u_recv (.clk(clk), .slow(slow), .rd_ready(rd_ready));
    always #2 clk = ~clk;
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // strobes held for exactly one edge, then deselect
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
        input logic [12:0] a);
        @(posedge clk) #1;
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(posedge clk) #1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
    endtask
    task automatic rd(input logic [2:0] s, input logic [1:0] bl,
        input logic bt, input logic q);
        logic [2:0] col;
        logic ch;
        int rl, n;
        ch = bl == 2'h2 || (bl == 2'h1 && s[1]);
        rl = 4 + s + (s % 3 == 0 ? 0 : 4 + s - s % 3);
        cmd(4'h0, 3'h1, {q, 7'h00, 2'(s % 3), 3'h0});
        cmd(4'h0, 3'h0, {4'h1, 2'h0, s, bt, s[0], bl});
        cmd(4'h5, 3'h0, {~s[1], 9'h000, s});
        n = 0;
        while (rd_valid_q !== 1'b1) begin
            @(posedge clk) #2;
            n++;
        end
        chk(n, rl);
        for (int i = 0; i < 8; i++) begin
            while (!(rd_valid_q === 1'b1 && rd_ready === 1'b1))
                @(posedge clk) #2;
            col = bt ? s ^ 3'(i) : {s[2] ^ i[2], s[1:0] + 2'(i)};
            chk(rd_col_q, col);
            chk(dq_oe_q, !q && (i < 4 || !ch));
            chk(dqs_oe_q, !q && (i < 4 || !ch));
            if (i < 4 || !ch)
                chk(rd_data_q, core_rd_words[col * 8 +: 8]);
            @(posedge clk) #2;
        end
        // no mode set until the burst has drained
        while (rd_busy_q !== 1'b0)
            @(posedge clk) #2;
    endtask
    task automatic wr(input logic [2:0] s, input logic [1:0] bl);
        logic ch;
        ch = bl == 2'h2 || (bl == 2'h1 && s[0]);
        cmd(4'h0, 3'h0, {4'h1, 5'h00, 1'b0, s[0], bl});
        cmd(4'h4, 3'h0, {~s[0], 9'h000, s});
        #1;
        chk(wr_cmd_q, 1'b1);
        chk(wr_start_col_q, ch ? {s[2], 2'h0} : 3'h0);
        chk(wr_chop_q, ch);
        chk(wr_pullin_q, bl == 2'h2 ? 4'h2 : 4'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        chk(opmode_q, 13'h0000);
        chk(ext1_q, 13'h0000);
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 16; k++) begin
                slow = k[1];
                rd(k[3:1], m[1:0], k[0], 1'b0);
                wr(k[2:0], m[1:0]);
            end
        end
        rd(3'h5, 2'h0, 1'b1, 1'b1);
        for (int w = 0; w < 8; w++) begin
            cmd(4'h0, 3'h0, {w[0], 3'(w), 9'h000});
            repeat (2) @(posedge clk);
            #1;
            chk(auto_pre_delay_q, (w == 0 ? 16 : w < 5 ? w + 4 : 2 * w) + 4);
            chk(pd_fast_exit_q, w[0]);
        end
        cmd(4'h0, 3'h0, 13'h0100);
        @(posedge clk) #1;
        chk(dll_reset_pulse_q, 1'b1);
        chk(opmode_q, 13'h0000);
        // no read follows the loop reset, so no lock wait is owed
        cmd(4'h0, 3'h2, 13'h1fff);
        @(posedge clk) #1;
        chk(opmode_q, 13'h0000);
        chk(test_mode_q, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
